/* rtl/fbl_defs.svh */
// Constants for the flag and branch logic of the 8-bit core.
// Assumes inclusion by bare name from rtl/ files only.
// Function
// - Advance PC to return address before push
// - Relative call 2 bytes, one cycle faster; here it takes the same cycles as the absolute call
// - Trap stacks state, vectors from FFFA/FFFB
// - Trap return restores stacked state
// - Idle instr stacks state then waits
// - Failed test falls through, success branches
// - Negative/positive branches test sign flag
// - Equal/unequal branches test zero flag
// - Overflow branches test overflow flag
// - Carry branches test carry flag
// - Higher needs C and Z clear
// - Less/ge use sign XOR overflow
// - Less-equal adds zero flag to less
// - Six-bit flags: H I N Z V C
// - Half-carry from add ops only
// - Mask set on entry/set op, cleared unmask
// - Sign copies bit 7, zero on zero result
// - Overflow and carry from arithmetic
// - Opcode 06 loads flags, 07 reads them
// - Opcodes 0B,0A,0D,0C touch overflow or carry
// - Opcodes 0F,0E set and clear mask
// - Signed pairs -128..+127, unsigned 00..FF
// - While idle, float buses, valid addr low
// - Idle exit sets mask; masked needs NMI
// - Branch target is PC+2 plus signed offset
`ifndef FBL_DEFS_SVH
`define FBL_DEFS_SVH
`define FBL_BIT_H 5
`define FBL_BIT_I 4
`define FBL_BIT_N 3
`define FBL_BIT_Z 2
`define FBL_BIT_V 1
`define FBL_BIT_C 0
`define FBL_FLAGS_RST 6'h10
`define FBL_TRAP_VEC_HI 16'hFFFA
`define FBL_TRAP_VEC_LO 16'hFFFB
`define FBL_OP_CLR_C 8'h0C
`define FBL_OP_CLR_V 8'h0A
`define FBL_OP_SET_V 8'h0B
`define FBL_OP_SET_C 8'h0D
`define FBL_OP_UNMASK 8'h0E
`define FBL_OP_MASK 8'h0F
`define FBL_OP_ACC_TO_FLAGS 8'h06
`define FBL_OP_FLAGS_TO_ACC 8'h07
`define FBL_OP_BR_LO 4'h2
`define FBL_OP_CALL_REL 8'h8D
`define FBL_OP_CALL_ABS 8'hBD
`define FBL_OP_TRAP 8'h3F
`define FBL_OP_IDLE 8'h3E
`define FBL_OP_TRET 8'h3B
`define FBL_LEN_REL 3'h2
`define FBL_LEN_ABS 3'h3
`define FBL_PUSH_PC 3'h2
`define FBL_PUSH_ALL 3'h7
`endif

/* rtl/fbl_pkg.sv */
// Types for the flag and branch logic.
// Assumes nothing beyond the constants header.
package fbl_pkg;
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic v;
		logic c;
	} fbl_flags_s;

	typedef enum logic [3:0] {
		FBL_ALU_NONE  = 4'h0,
		FBL_ALU_ADD   = 4'h1,
		FBL_ALU_ADC   = 4'h2,
		FBL_ALU_SUM   = 4'h3,
		FBL_ALU_SUB   = 4'h4,
		FBL_ALU_LOGIC = 4'h5
	} fbl_alu_e;

	typedef struct packed {
		logic       valid;
		fbl_alu_e   op;
		logic [7:0] res;
		logic       c;
		logic       v;
		logic       h;
	} fbl_alu_s;

	typedef enum logic [6:0] {
		FBL_ST_RUN   = 7'h01,
		FBL_ST_PUSH  = 7'h02,
		FBL_ST_VHI   = 7'h04,
		FBL_ST_VLO   = 7'h08,
		FBL_ST_PULL  = 7'h10,
		FBL_ST_IDLE  = 7'h20,
		FBL_ST_FETCH = 7'h40
	} fbl_state_e;
endpackage

/* rtl/fbl_cond.sv */
// Branch condition evaluator: low opcode nibble against current flags.
// Assumes the flags arrive already updated by the prior instruction.
`timescale 1ns/1ps
`include "fbl_defs.svh"
module fbl_cond (
	input  wire logic [3:0] sel,
	input  wire logic [5:0] flags,
	output logic            taken
);
	logic n;
	logic z;
	logic v;
	logic c;
	logic lt;
	logic base;

	always_comb begin
		n = flags[`FBL_BIT_N];
		z = flags[`FBL_BIT_Z];
		v = flags[`FBL_BIT_V];
		c = flags[`FBL_BIT_C];
		// Signed ordering over -128..+127
		lt = n ^ v;
		// Even codes test the true sense, odd ones invert
		case (sel[3:1])
			3'h0: base = 1'b1;
			3'h1: base = ~(c | z);
			3'h2: base = ~c;
			3'h3: base = ~z;
			3'h4: base = ~v;
			3'h5: base = ~n;
			3'h6: base = ~lt;
			3'h7: base = ~(z | lt);
			default: base = 1'b0;
		endcase
		taken = sel[0] ? ~base : base;
		if (sel == 4'h1)
			taken = 1'b0;
	end
endmodule

/* rtl/fbl_core.sv */
// Flag register and control-flow sequencer of the 8-bit core.
// Assumes an external decoder presents one opcode at a time with its
// operands, and that memory answers a read in the cycle after request.
`timescale 1ns/1ps
`include "fbl_defs.svh"
module fbl_core (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              op_valid,
	input  wire logic [7:0]        opcode,
	input  wire logic [15:0]       op_pc,
	input  wire logic [15:0]       op_operand,
	input  wire logic [7:0]        acc_a,
	input  wire fbl_pkg::fbl_alu_s alu,
	input  wire logic              irq_n,
	input  wire logic              nmi_n,
	input  wire logic [7:0]        mem_rdata,
	input  wire logic [5:0]        stacked_flags,
	output logic                   op_ready,
	output logic [5:0]             flag_register,
	output logic [7:0]             flags_to_acc,
	output logic                   pc_load,
	output logic [15:0]            pc_next,
	output logic                   push_req,
	output logic [15:0]            push_pc,
	output logic [2:0]             push_count,
	output logic                   pull_req,
	output logic                   mem_rd,
	output logic [15:0]            mem_addr,
	output logic                   valid_addr_flag,
	output logic                   bus_oe,
	output logic [2:0]             instr_len
);
	fbl_pkg::fbl_flags_s flags_q;
	fbl_pkg::fbl_flags_s flags_d;
	fbl_pkg::fbl_state_e state_q;
	fbl_pkg::fbl_state_e state_d;
	logic [2:0]  irq_sync_q;
	logic [2:0]  nmi_sync_q;
	logic        irq_q;
	logic        nmi_q;
	logic        br_taken;
	logic        is_branch;
	logic [15:0] ret_pc;
	logic [15:0] br_target;
	logic [7:0]  vec_hi_q;
	logic        accept;
	logic        idle_q;
	logic        is_call;

	assign accept = op_valid && state_q == fbl_pkg::FBL_ST_RUN;
	assign op_ready = state_q == fbl_pkg::FBL_ST_RUN;
	assign is_branch = opcode[7:4] == `FBL_OP_BR_LO;
	assign is_call = opcode == `FBL_OP_CALL_REL ||
	    opcode == `FBL_OP_CALL_ABS;

	fbl_cond u_cond (
		.sel   (opcode[3:0]),
		.flags (flags_q),
		.taken (br_taken)
	);

	// Pins are asynchronous: three stages, change seen when last two agree
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_sync_q <= 3'h7;
			nmi_sync_q <= 3'h7;
			irq_q      <= 1'b0;
			nmi_q      <= 1'b0;
		end else begin
			irq_sync_q <= {irq_sync_q[1:0], irq_n};
			nmi_sync_q <= {nmi_sync_q[1:0], nmi_n};
			if (irq_sync_q[1] == irq_sync_q[2])
				irq_q <= ~irq_sync_q[2];
			if (nmi_sync_q[1] == nmi_sync_q[2])
				nmi_q <= ~nmi_sync_q[2];
		end
	end

	// Return address is past the whole call/trap encoding
	always_comb begin
		instr_len = 3'h1;
		if (is_branch || opcode == `FBL_OP_CALL_REL)
			instr_len = `FBL_LEN_REL;
		else if (opcode == `FBL_OP_CALL_ABS)
			instr_len = `FBL_LEN_ABS;
		ret_pc = op_pc + {13'h0000, instr_len};
		br_target = ret_pc + {{8{op_operand[7]}}, op_operand[7:0]};
	end

	// Flag update; registered, so the next branch sees it from the following cycle
	always_comb begin
		flags_d = flags_q;
		if (accept && alu.valid && alu.op != fbl_pkg::FBL_ALU_NONE) begin
			flags_d.n = alu.res[7];
			flags_d.z = alu.res == 8'h00;
			if (alu.op != fbl_pkg::FBL_ALU_LOGIC) begin
				flags_d.v = alu.v;
				flags_d.c = alu.c;
			end else
				flags_d.v = 1'b0;
			if (alu.op == fbl_pkg::FBL_ALU_ADD ||
			    alu.op == fbl_pkg::FBL_ALU_ADC ||
			    alu.op == fbl_pkg::FBL_ALU_SUM)
				flags_d.h = alu.h;
		end
		if (accept) begin
			case (opcode)
				`FBL_OP_CLR_C: flags_d.c = 1'b0;
				`FBL_OP_SET_C: flags_d.c = 1'b1;
				`FBL_OP_CLR_V: flags_d.v = 1'b0;
				`FBL_OP_SET_V: flags_d.v = 1'b1;
				`FBL_OP_UNMASK: flags_d.i = 1'b0;
				`FBL_OP_MASK: flags_d.i = 1'b1;
				`FBL_OP_ACC_TO_FLAGS: flags_d = acc_a[5:0];
				default: ;
			endcase
		end
		// Stacked state reloaded, mask included
		if (state_q == fbl_pkg::FBL_ST_PULL)
			flags_d = stacked_flags;
		// Software or hardware entry masks further interrupts
		if (state_q == fbl_pkg::FBL_ST_PUSH && !idle_q)
			flags_d.i = 1'b1;
		if (state_q == fbl_pkg::FBL_ST_IDLE &&
		    (nmi_q || (irq_q && !flags_q.i)))
			flags_d.i = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			flags_q <= `FBL_FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			fbl_pkg::FBL_ST_RUN: begin
				if (accept && (opcode == `FBL_OP_TRAP ||
				    opcode == `FBL_OP_IDLE))
					state_d = fbl_pkg::FBL_ST_PUSH;
				else if (accept && opcode == `FBL_OP_TRET)
					state_d = fbl_pkg::FBL_ST_PULL;
			end
			fbl_pkg::FBL_ST_PUSH:
				state_d = idle_q ?
				    fbl_pkg::FBL_ST_IDLE : fbl_pkg::FBL_ST_VHI;
			fbl_pkg::FBL_ST_VHI: state_d = fbl_pkg::FBL_ST_VLO;
			fbl_pkg::FBL_ST_VLO: state_d = fbl_pkg::FBL_ST_FETCH;
			fbl_pkg::FBL_ST_FETCH: state_d = fbl_pkg::FBL_ST_RUN;
			fbl_pkg::FBL_ST_PULL: state_d = fbl_pkg::FBL_ST_RUN;
			fbl_pkg::FBL_ST_IDLE:
				// Masked request cannot end the wait
				if (nmi_q || (irq_q && !flags_q.i))
					state_d = fbl_pkg::FBL_ST_RUN;
			default: state_d = fbl_pkg::FBL_ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			state_q <= fbl_pkg::FBL_ST_RUN;
		else
			state_q <= state_d;
	end

	// High vector byte held until the low one arrives
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			vec_hi_q <= 8'h00;
		else if (state_q == fbl_pkg::FBL_ST_VLO)
			vec_hi_q <= mem_rdata;
	end

	// Latched at acceptance: the decoder may move on during the sequence
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			idle_q <= 1'b0;
		else if (accept)
			idle_q <= opcode == `FBL_OP_IDLE;
	end

	// Status copy for the accumulator; flags stay as they are
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			flags_to_acc <= 8'h00;
		else if (accept && opcode == `FBL_OP_FLAGS_TO_ACC)
			flags_to_acc <= {2'h3, flags_q};
	end

	// Program counter redirect: branch, call or trap vector
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pc_load <= 1'b0;
			pc_next <= 16'h0000;
		end else begin
			pc_load <= 1'b0;
			if (accept && is_branch) begin
				pc_load <= 1'b1;
				// Fall through or jump
				pc_next <= br_taken ? br_target : ret_pc;
			end
			if (accept && is_call) begin
				pc_load <= 1'b1;
				pc_next <= opcode == `FBL_OP_CALL_REL ?
				    br_target : op_operand;
			end
			if (state_q == fbl_pkg::FBL_ST_FETCH) begin
				pc_load <= 1'b1;
				pc_next <= {vec_hi_q, mem_rdata};
			end
		end
	end

	// Stack push: the return address is already advanced here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			push_req   <= 1'b0;
			push_pc    <= 16'h0000;
			push_count <= 3'h0;
		end else begin
			push_req <= 1'b0;
			if (accept && is_call) begin
				push_req   <= 1'b1;
				push_pc    <= ret_pc;
				push_count <= `FBL_PUSH_PC;
			end
			if (accept && (opcode == `FBL_OP_TRAP ||
			    opcode == `FBL_OP_IDLE)) begin
				push_req   <= 1'b1;
				push_pc    <= ret_pc;
				push_count <= `FBL_PUSH_ALL;
			end
		end
	end

	// Stack pull request for the trap return
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			pull_req <= 1'b0;
		else
			pull_req <= accept && opcode == `FBL_OP_TRET;
	end

	always_comb begin
		mem_rd   = state_q == fbl_pkg::FBL_ST_VHI ||
		    state_q == fbl_pkg::FBL_ST_VLO;
		mem_addr = state_q == fbl_pkg::FBL_ST_VLO ?
		    `FBL_TRAP_VEC_LO : `FBL_TRAP_VEC_HI;
		// Buses released while waiting
		bus_oe          = state_q != fbl_pkg::FBL_ST_IDLE;
		valid_addr_flag = state_q != fbl_pkg::FBL_ST_IDLE;
	end

	assign flag_register = flags_q;
endmodule

/* dv/fbl_mem_model.sv */
// Vector memory seen by the core during a trap.
// Assumes reads are answered on the next clock.
`timescale 1ns/1ps
module fbl_mem_model #(parameter logic [15:0] VEC = 16'h4321) (
	input  logic        core_clk,
	input  logic        mem_rd,
	input  logic [15:0] mem_addr,
	output logic [7:0]  mem_rdata
);
	// Flip unread data so a stale byte never passes as a vector
	always_ff @(posedge core_clk) begin
		if (mem_rd && mem_addr[15:1] == 15'h7FFD)
			mem_rdata <= mem_addr[0] ? VEC[7:0] : VEC[15:8];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule

/* dv/fbl_core_sva.sv */
// Assertions on the flag and branch sequencer ports.
// Assumes one clock domain; bound into the core below.
`timescale 1ns/1ps
module fbl_core_sva (
	input logic        core_clk,
	input logic        rst_n,
	input logic        op_valid,
	input logic        op_ready,
	input logic [7:0]  opcode,
	input logic [15:0] op_pc,
	input logic [15:0] op_operand,
	input logic [7:0]  acc_a,
	input logic [5:0]  flag_register,
	input logic        pc_load,
	input logic [15:0] pc_next,
	input logic        push_req,
	input logic [15:0] push_pc,
	input logic [2:0]  push_count,
	input logic        mem_rd,
	input logic [15:0] mem_addr,
	input logic        valid_addr_flag
);
	logic        tk;
	logic [5:0]  acc;
	logic [15:0] tgt;
	assign tk = op_valid && op_ready;
	assign acc = acc_a[5:0];
	assign tgt = op_pc + 16'h2 + {{8{op_operand[7]}}, op_operand[7:0]};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	trap_push_a: assert property (tk && opcode == 8'h3F |=>
		push_req && push_count == 3'h7) else $error("trap push");
	trap_vec_a: assert property (tk && opcode == 8'h3F |-> ##2
		mem_rd && mem_addr == 16'hFFFA ##1 mem_rd && mem_addr == 16'hFFFB)
		else $error("trap vector");
	call_ret_a: assert property (tk && opcode == 8'hBD |=>
		push_req && push_pc == $past(op_pc) + 16'h3) else $error("return");
	br_tgt_a: assert property (tk && opcode == 8'h27
		&& flag_register[2] |=> pc_load && pc_next == $past(tgt))
		else $error("branch target");
	tap_load_a: assert property (tk && opcode == 8'h06 |=>
		flag_register == $past(acc)) else $error("flag load");
	set_ovf_a: assert property (tk && opcode == 8'h0B |=>
		flag_register == ($past(flag_register) | 6'h02))
		else $error("set overflow");
	unmask_a: assert property (tk && opcode == 8'h0E |=>
		flag_register == ($past(flag_register) & 6'h2F))
		else $error("unmask");
	idle_float_a: assert property (tk && opcode == 8'h3E |->
		##2 !valid_addr_flag) else $error("idle bus");
	idle_push_a: assert property (tk && opcode == 8'h3E |=>
		push_req && push_count == 3'h7) else $error("idle push");
	rel_call_a: assert property (tk && opcode == 8'h8D |=>
		push_count == 3'h2 && pc_next == $past(tgt)) else $error("rel call");
	trap_c: cover property (tk && opcode == 8'h3F);
	idle_c: cover property (tk && opcode == 8'h3E);
	call_c: cover property (tk && opcode == 8'h8D);
endmodule
bind fbl_core fbl_core_sva chk_u (.core_clk, .rst_n, .op_valid, .op_ready,
	.opcode, .op_pc, .op_operand, .acc_a, .flag_register, .pc_load,
	.pc_next, .push_req, .push_pc, .push_count, .mem_rd, .mem_addr,
	.valid_addr_flag);

/* dv/testbench.sv */
// Bench driving opcodes into the flag and branch sequencer.
// Assumes the memory model supplies the trap vector bytes.
`timescale 1ns/1ps
module testbench;
	logic              core_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
	logic              irq_n = 1'b1, op_ready, pc_load, mem_rd, vaf;
	logic              nmi_n = 1'b1, push_req, pull_req, bus_oe;
	logic [2:0]        push_count, ilen;
	logic [7:0]        opcode = 8'h01, acc_a = 8'h0, mem_rdata, f2a;
	logic [15:0]       op_operand = 16'h0, pc_next, push_pc, mem_addr, e;
	logic [5:0]        flag_register;
	fbl_pkg::fbl_alu_s alu = '0;
	int                num_errors = 0, check_count = 0;
	localparam logic [7:0] FO [6] = '{8'h0D, 8'h0B, 8'h0A,
		8'h0C, 8'h0E, 8'h0F};
	localparam logic [5:0] FE [6] = '{6'h11, 6'h13, 6'h11,
		6'h10, 6'h00, 6'h10};
	fbl_core dut_u (.core_clk, .rst_n, .op_valid, .opcode,
		.op_pc(16'h1000), .op_operand, .acc_a, .alu, .irq_n,
		.nmi_n, .mem_rdata, .stacked_flags(6'h05), .op_ready,
		.flag_register, .flags_to_acc(f2a), .pc_load, .pc_next,
		.push_req, .push_pc, .push_count, .pull_req, .mem_rd,
		.mem_addr, .valid_addr_flag(vaf), .bus_oe, .instr_len(ilen));
	fbl_mem_model mem_u (.core_clk, .mem_rd, .mem_addr, .mem_rdata);
	task automatic chk(input string n, input logic [15:0] x, y);
		check_count++;
		if (x !== y) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, x, y);
		end
	endtask
	// Leaves the request up so a following call can run back to back
	task automatic op(input logic [7:0] o, input logic [15:0] d,
		input fbl_pkg::fbl_alu_s a = '0);
		op_valid <= 1'b1;
		opcode <= o;
		op_operand <= d;
		acc_a <= d[7:0];
		alu <= a;
		// Ready is read on the falling edge, where it has settled
		@(negedge core_clk);
		for (int i = 0; i < 20 && op_ready !== 1'b1; i++)
			@(negedge core_clk);
		@(posedge core_clk);
	endtask
	task automatic run(input logic [7:0] o, input logic [15:0] d,
		input fbl_pkg::fbl_alu_s a = '0);
		@(posedge core_clk);
		op(o, d, a);
		op_valid <= 1'b0;
		@(negedge core_clk);
	endtask
	function automatic logic taken(input logic [3:0] s, f);
		logic [6:0] t;
		t[0] = f[0] | f[2];
		t[1] = f[0];
		t[2] = f[2];
		t[3] = f[1];
		t[4] = f[3];
		t[5] = f[3] ^ f[1];
		t[6] = f[2] | t[5];
		return s[0] ? t[s[3:1] - 3'h1] : !t[s[3:1] - 3'h1];
	endfunction
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#20000;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk("reset", 16'h10, 16'(flag_register));
		foreach (FO[i]) begin
			run(FO[i], 16'h0);
			chk("flagop", 16'(FE[i]), 16'(flag_register));
		end
		run(8'h06, 16'h15);
		run(8'h07, 16'h0);
		chk("read", 16'hD5, 16'(f2a));
		$display("flag ops done");
		// Alu word: valid, op, result, then c v h
		run(8'h8B, 16'h0, 16'h8C03);
		chk("add", 16'h3A, 16'(flag_register));
		run(8'h8B, 16'h0, 16'hA806);
		chk("logic", 16'h34, 16'(flag_register));
		run(8'h8B, 16'h0, 16'h9881);
		chk("sum", 16'h30, 16'(flag_register));
		run(8'h8B, 16'h0, 16'hA006);
		chk("sub", 16'h37, 16'(flag_register));
		run(8'h8B, 16'h0, 16'h9000);
		chk("adc", 16'h14, 16'(flag_register));
		$display("alu flags done");
		for (int s = 2; s < 16; s++) begin
			for (int f = 0; f < 16; f++) begin
				@(posedge core_clk);
				op(8'h06, 16'(f));
				op(8'(32 + s), 16'h00F0);
				op_valid <= 1'b0;
				@(negedge core_clk);
				e = taken(4'(s), 4'(f)) ? 16'h0FF2 : 16'h1002;
				chk("target", e, pc_next);
			end
		end
		$display("branches done");
		run(8'hBD, 16'h2000);
		chk("ret", 16'h1003, push_pc);
		chk("push", 16'h1, 16'(push_req));
		chk("count", 16'h2, 16'(push_count));
		chk("jump", 16'h2000, pc_next);
		chk("len", 16'h3, 16'(ilen));
		run(8'h8D, 16'h0010);
		chk("ret", 16'h1002, push_pc);
		chk("dest", 16'h1012, pc_next);
		chk("len", 16'h2, 16'(ilen));
		run(8'h3F, 16'h0);
		chk("count", 16'h7, 16'(push_count));
		for (int i = 0; i < 10 && pc_load !== 1'b1; i++)
			@(negedge core_clk);
		chk("vector", 16'h4321, pc_next);
		chk("mask", 16'h1, 16'(flag_register[4]));
		run(8'h3B, 16'h0);
		chk("pull", 16'h1, 16'(pull_req));
		@(negedge core_clk);
		chk("restore", 16'h05, 16'(flag_register));
		$display("calls and traps done");
		run(8'h3E, 16'h0);
		chk("count", 16'h7, 16'(push_count));
		repeat (2) @(negedge core_clk);
		chk("float", 16'h0, 16'(vaf));
		chk("bus", 16'h0, 16'(bus_oe));
		@(posedge core_clk);
		irq_n <= 1'b0;
		for (int i = 0; i < 20 && op_ready !== 1'b1; i++)
			@(negedge core_clk);
		chk("wake", 16'h1, 16'(flag_register[4]));
		run(8'h3E, 16'h0);
		repeat (12) @(negedge core_clk);
		chk("masked", 16'h0, 16'(op_ready));
		@(posedge core_clk);
		nmi_n <= 1'b0;
		for (int i = 0; i < 20 && op_ready !== 1'b1; i++)
			@(negedge core_clk);
		chk("nmi wake", 16'h1, 16'(op_ready));
		$display("idle done");
		print_verdict();
	end
endmodule
